/* File: hw/fsc_top.sv */
// Identification and security register command handling of the serial flash.
`timescale 1ns/1ns
module fsc_top
    import fsc_pkg::*;
#(
    parameter logic [7:0] MFR_ID = 8'h5A,         // Arbitrary value.
    parameter logic [7:0] DEV_ID = 8'h17,         // Arbitrary value.
    parameter logic [7:0] MEM_TYPE = 8'h40,       // Arbitrary value.
    parameter logic [7:0] CAPACITY = 8'h18,       // Arbitrary value.
    parameter logic [63:0] UNIQUE_ID = 64'h0123456789ABCDEF, // Arbitrary.
    parameter int ERASE_CYCLES = SE_CYCLES,
    parameter int PROG_CYCLES = SP_CYCLES
)
(
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic spi_clk,
    input wire logic cs_n,
    input wire logic [3:0] io_in,
    output logic [3:0] io_out,
    output logic [3:0] io_oe,
    input wire logic write_enable_latch,
    input wire logic [2:0] otp_lock_bits,
    output logic busy,
    output logic latch_clr
);

    // ****************************************************************
    // Elaboration checks
    // ****************************************************************
    if (ERASE_CYCLES <= SEC_BYTES)
        $error("ERASE_CYCLES must exceed the bytes of one register");
    if (PROG_CYCLES < 1)
        $error("PROG_CYCLES must be at least one");

    // ****************************************************************
    // Serial clock domain: frame decode
    // ****************************************************************
    logic frame_rst_n;
    logic [6:0] cnt_r;
    logic [6:0] cnt_nxt;
    logic [31:0] isr_r;
    logic [31:0] isr_nxt;
    logic [7:0] cmd_r;
    logic [7:0] op_now;
    logic [23:0] addr_r;
    logic [23:0] addr_now;
    logic [6:0] start;
    logic is_out;
    logic has_phase;
    logic quad;
    logic data_edge;
    logic load_now;
    logic byte_done;
    logic [2:0] dph_r;
    logic [2:0] dph_inc;
    logic [7:0] idx_r;
    logic [7:0] idx_cur;
    logic out_ok_r;
    logic op_out_id;
    logic busy_s;
    logic [7:0] sh_r;
    logic [7:0] load_val;
    logic [7:0] jedec_b;
    logic [7:0] quad_b;
    logic [63:0] uid_sh;
    logic [7:0] tptr;
    logic [31:0] sig_sh;
    logic [7:0] table_b;
    logic [7:0] nb_r;
    logic rq_tog_r;
    fsc_ptr_s rq_ptr_r;
    logic ack_tog_r;
    logic ack_s;
    logic wr_tog_r;
    fsc_wr_s wr_r;
    fsc_arm_s arm_r;
    logic rd_start;
    logic [7:0] rd_data_r;

    // The frame logic restarts whenever chip select is high.
    assign frame_rst_n = reset_n & ~cs_n;
    assign isr_nxt = {isr_r[30:0], io_in[0]};
    assign cnt_nxt = (cnt_r == CNT_MAX) ? cnt_r : cnt_r + 7'd1;
    assign op_now = (cnt_nxt == OPC_BITS) ? isr_nxt[7:0] : cmd_r;
    assign addr_now = isr_nxt[23:0];
    assign quad = (op_now == OP_QUAD_ID);
    assign op_out_id = quad || (op_now == OP_JEDEC) || (op_now == OP_UID);
    assign is_out = op_out_id || (op_now == OP_TABLE) ||
        (op_now == OP_SEC_READ);
    assign has_phase = is_out || (op_now == OP_SEC_PROG);
    assign start = (op_now == OP_JEDEC) ? START_JEDEC :
        quad ? START_QUAD :
        (op_now == OP_SEC_PROG) ? ADDR_DONE : START_LONG;
    assign data_edge = has_phase && (cnt_nxt >= start);
    assign load_now = data_edge && ((cnt_nxt == start) || (dph_r == 3'd0));
    assign byte_done = load_now && (cnt_nxt != start);
    assign dph_inc = quad ? {2'b00, ~dph_r[0]} : dph_r + 3'd1;
    assign idx_cur = (cnt_nxt == start) ? 8'h00 : idx_r;
    assign rd_start = (cnt_nxt == ADDR_DONE) && (cmd_r == OP_SEC_READ) &&
        sec_valid(addr_now) && !busy_s;

    // ****************************************************************
    // Serial clock domain: output byte selection
    // ****************************************************************
    assign jedec_b = (idx_cur == 8'h00) ? MFR_ID :
        (idx_cur == 8'h01) ? MEM_TYPE :
        (idx_cur == 8'h02) ? CAPACITY : BYTE_NONE;
    assign quad_b = idx_cur[0] ? DEV_ID : MFR_ID;
    assign uid_sh = UNIQUE_ID << {idx_cur[2:0], 3'b000};
    assign tptr = addr_r[7:0] + idx_cur;
    assign sig_sh = TABLE_SIGNATURE >> {tptr[1:0], 3'b000};
    assign table_b = (tptr < TABLE_SIG_BYTES) ? sig_sh[7:0] : TABLE_FILL;
    assign load_val = (op_now == OP_JEDEC) ? jedec_b :
        quad ? quad_b :
        (op_now == OP_UID) ? uid_sh[63:56] :
        (op_now == OP_TABLE) ? table_b : nb_r;

    fsc_sync #(.WIDTH(2)) u_sync_spi
    (
        .clk(spi_clk),
        .reset_n(reset_n),
        .d({busy, ack_tog_r}),
        .q({busy_s, ack_s})
    );

    // Opcode, address and position in the frame.
    always_ff @(posedge spi_clk or negedge frame_rst_n)
    begin
        if (!frame_rst_n)
        begin
            cnt_r <= 7'h00;
            isr_r <= 32'h0000_0000;
            cmd_r <= 8'h00;
            addr_r <= 24'h00_0000;
        end
        else
        begin
            cnt_r <= cnt_nxt;
            isr_r <= isr_nxt;
            if (cnt_nxt == OPC_BITS)
                cmd_r <= isr_nxt[7:0];
            if (cnt_nxt == ADDR_DONE)
                addr_r <= addr_now;
        end
    end

    // Byte phase, byte index, output permission and output shifter.
    always_ff @(posedge spi_clk or negedge frame_rst_n)
    begin
        if (!frame_rst_n)
        begin
            dph_r <= 3'd0;
            idx_r <= 8'h00;
            out_ok_r <= 1'b0;
            sh_r <= 8'h00;
        end
        else
        begin
            if (data_edge)
                dph_r <= (cnt_nxt == start) ? 3'd1 : dph_inc;
            if (load_now)
                idx_r <= idx_cur + 8'h01;
            if (cnt_nxt == OPC_BITS)
                out_ok_r <= op_out_id;
            else if ((cnt_nxt == ADDR_DONE) && (cmd_r == OP_TABLE))
                out_ok_r <= (addr_now[23:8] == 16'h0000);
            else if ((cnt_nxt == ADDR_DONE) && (cmd_r == OP_SEC_READ))
                out_ok_r <= rd_start;
            if (load_now)
                sh_r <= load_val;
            else if (data_edge)
                sh_r <= quad ? {sh_r[3:0], 4'h0} : {sh_r[6:0], 1'b0};
        end
    end

    // Output pins change on the falling edge, most significant bits first.
    always_ff @(negedge spi_clk or negedge frame_rst_n)
    begin
        if (!frame_rst_n)
        begin
            io_out <= 4'h0;
            io_oe <= 4'h0;
        end
        else if (out_ok_r && is_out && (cnt_r >= start))
        begin
            io_out <= quad ? sh_r[7:4] : {2'b00, sh_r[7], 1'b0};
            io_oe <= quad ? 4'hF : 4'h2;
        end
        else
        begin
            io_out <= 4'h0;
            io_oe <= 4'h0;
        end
    end

    // ****************************************************************
    // Serial clock domain: crossings that outlive the frame
    // ****************************************************************
    always_ff @(posedge spi_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rq_tog_r <= 1'b0;
            rq_ptr_r <= '0;
            nb_r <= 8'h00;
            wr_tog_r <= 1'b0;
            wr_r <= '0;
            arm_r <= '0;
        end
        else
        begin
            if (rd_start)
            begin
                rq_ptr_r <= {addr_now[13:12], addr_now[7:0]};
                rq_tog_r <= ~rq_tog_r;
            end
            else if (load_now && (op_now == OP_SEC_READ) && out_ok_r)
            begin
                rq_ptr_r.byte_addr <= rq_ptr_r.byte_addr + 8'h01;
                rq_tog_r <= ~rq_tog_r;
            end
            if (ack_s == rq_tog_r)
                nb_r <= rd_data_r;
            if (byte_done && (op_now == OP_SEC_PROG) && sec_valid(addr_r))
            begin
                wr_r.ptr.sreg <= addr_r[13:12];
                wr_r.ptr.byte_addr <= addr_r[7:0] + idx_r - 8'h01;
                wr_r.data <= isr_nxt[7:0];
                wr_tog_r <= ~wr_tog_r;
            end
            arm_r.erase <= (cnt_nxt == ADDR_DONE) &&
                (cmd_r == OP_SEC_ERASE) && sec_valid(addr_now);
            arm_r.prog <= (cmd_r == OP_SEC_PROG) &&
                (cnt_nxt >= START_LONG) && sec_valid(addr_r);
            arm_r.sreg <= (cnt_nxt == ADDR_DONE) ? addr_now[13:12] :
                addr_r[13:12];
        end
    end

    // ****************************************************************
    // System clock domain: crossings in
    // ****************************************************************
    logic cs_s;
    logic cs_q_r;
    logic cs_rise;
    fsc_arm_s arm_s;
    logic rq_pulse;
    logic wr_pulse;

    fsc_sync #(.WIDTH(5)) u_sync_sys
    (
        .clk(clk_sys),
        .reset_n(reset_n),
        .d({cs_n, arm_r}),
        .q({cs_s, arm_s})
    );

    fsc_tog_rx u_rq_rx
    (
        .clk(clk_sys),
        .reset_n(reset_n),
        .tog(rq_tog_r),
        .pulse(rq_pulse)
    );

    fsc_tog_rx u_wr_rx
    (
        .clk(clk_sys),
        .reset_n(reset_n),
        .tog(wr_tog_r),
        .pulse(wr_pulse)
    );

    assign cs_rise = cs_s & ~cs_q_r;

    // ****************************************************************
    // System clock domain: self-timed cycles
    // ****************************************************************
    fsc_state_e state_r;
    logic [31:0] timer_r;
    logic [1:0] esreg_r;
    logic [7:0] er_idx_r;
    logic er_done_r;
    logic [2:0] lock_sh;
    logic arm_lock;
    logic [2:0] wr_lock_sh;
    logic pg_we;
    logic er_we;
    logic go_erase;
    logic go_prog;
    logic [9:0] er_a;
    logic [9:0] pg_a;
    logic [9:0] rd_a;
    logic [7:0] mem [SEC_REGS*SEC_BYTES];

    assign lock_sh = otp_lock_bits >> (arm_s.sreg - 2'd1);
    assign arm_lock = lock_sh[0];
    assign wr_lock_sh = otp_lock_bits >> (wr_r.ptr.sreg - 2'd1);
    assign go_erase = cs_rise && (state_r == ST_IDLE) && arm_s.erase &&
        write_enable_latch && !arm_lock;
    assign go_prog = cs_rise && (state_r == ST_IDLE) && arm_s.prog &&
        write_enable_latch && !arm_lock;
    assign pg_we = wr_pulse && (state_r == ST_IDLE) && write_enable_latch &&
        (wr_r.ptr.sreg != 2'b00) && !wr_lock_sh[0];
    assign er_we = (state_r == ST_ERASE) && !er_done_r;
    assign er_a = {esreg_r - 2'd1, er_idx_r};
    assign pg_a = {wr_r.ptr.sreg - 2'd1, wr_r.ptr.byte_addr};
    assign rd_a = {rq_ptr_r.sreg - 2'd1, rq_ptr_r.byte_addr};

    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            cs_q_r <= 1'b0;
            state_r <= ST_IDLE;
            timer_r <= 32'h0000_0000;
            esreg_r <= 2'b01;
            er_idx_r <= 8'h00;
            er_done_r <= 1'b0;
            busy <= 1'b0;
            latch_clr <= 1'b0;
            ack_tog_r <= 1'b0;
        end
        else
        begin
            cs_q_r <= cs_s;
            latch_clr <= 1'b0;
            ack_tog_r <= ack_tog_r ^ rq_pulse;
            case (state_r)
                ST_IDLE:
                begin
                    if (go_erase)
                    begin
                        state_r <= ST_ERASE;
                        timer_r <= 32'(ERASE_CYCLES - 1);
                        esreg_r <= arm_s.sreg;
                        er_idx_r <= 8'h00;
                        er_done_r <= 1'b0;
                        busy <= 1'b1;
                    end
                    else if (go_prog)
                    begin
                        state_r <= ST_PROG;
                        timer_r <= 32'(PROG_CYCLES - 1);
                        busy <= 1'b1;
                    end
                end
                ST_ERASE, ST_PROG:
                begin
                    if (er_we)
                    begin
                        er_idx_r <= er_idx_r + 8'h01;
                        er_done_r <= (er_idx_r == BYTE_LAST);
                    end
                    if (timer_r == 32'h0000_0000)
                    begin
                        state_r <= ST_IDLE;
                        busy <= 1'b0;
                        latch_clr <= 1'b1;
                    end
                    else
                        timer_r <= timer_r - 32'h0000_0001;
                end
                default:
                begin
                    state_r <= ST_IDLE;
                    busy <= 1'b0;
                end
            endcase
        end
    end

    // Programming only clears bits, so cells must be erased to take data.
    always_ff @(posedge clk_sys)
    begin
        if (er_we)
            mem[er_a] <= BYTE_ERASED;
        else if (pg_we)
            mem[pg_a] <= mem[pg_a] & wr_r.data;
        if (rq_pulse)
            rd_data_r <= mem[rd_a];
    end

endmodule

/* File: hw/fsc_pkg.sv */
// Constants, carrier types and helpers of the flash identification and security command block.
// Function
// - Quad identification read: opcode 94h, four dummy clocks, 24-bit zero address four bits per clock.
// - Quad identification output: manufacturer then device code, nibbles on falling edges, MSB first.
// - Quad identification codes alternate until chip select rises.
// - Unique ID read: opcode 4Bh, four dummy bytes, then fixed 64-bit number on falling edges.
// - JEDEC read 9Fh: manufacturer, memory type, capacity bytes, falling edges, MSB first.
// - Table read 5Ah: address, eight dummy clocks, output from falling edge of clock 40.
// - Table read: upper sixteen address bits zero, low byte selects the start byte.
// - Security erase 44h is accepted only with the write enable latch set.
// - Security register chosen by address bits 15:12 equal to 1, 2 or 3.
// - Security erase runs only if chip select rises right after the address.
// - Security erase is self-timed with busy high, busy low when finished.
// - Write enable latch cleared when the security erase finishes.
// - A set lock bit blocks erase and program of its security register.
// - Security program 42h with latch set writes one to 256 bytes into erased cells.
// - Security read 48h: address and eight dummy clocks, then bytes on falling edges.
// - Security read address increments, wraps FFh to 00h until chip select rises.
// - Security read issued while busy is ignored and leaves the cycle alone.
package fsc_pkg;

    // ****************************************************************
    // Opcodes and frame positions in serial clocks
    // ****************************************************************
    localparam logic [7:0] OP_QUAD_ID = 8'h94;
    localparam logic [7:0] OP_UID = 8'h4B;
    localparam logic [7:0] OP_JEDEC = 8'h9F;
    localparam logic [7:0] OP_TABLE = 8'h5A;
    localparam logic [7:0] OP_SEC_ERASE = 8'h44;
    localparam logic [7:0] OP_SEC_PROG = 8'h42;
    localparam logic [7:0] OP_SEC_READ = 8'h48;
    localparam logic [6:0] OPC_BITS = 7'h08;
    localparam logic [6:0] ADDR_DONE = 7'h20;
    localparam logic [6:0] START_JEDEC = 7'h08;
    localparam logic [6:0] START_QUAD = 7'h14;
    localparam logic [6:0] START_LONG = 7'h28;
    localparam logic [6:0] CNT_MAX = 7'h7F;

    // ****************************************************************
    // Security registers and parameter table
    // ****************************************************************
    localparam int SEC_REGS = 3;
    localparam int SEC_BYTES = 256;
    localparam logic [7:0] BYTE_ERASED = 8'hFF;
    localparam logic [7:0] BYTE_LAST = 8'hFF;
    localparam logic [7:0] BYTE_NONE = 8'h00;
    localparam logic [31:0] TABLE_SIGNATURE = 32'h50444653;
    localparam logic [7:0] TABLE_SIG_BYTES = 8'h04;
    localparam logic [7:0] TABLE_FILL = 8'hFF;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int CLK_MHZ = 125;
    localparam int SECURITY_ERASE_TIME_US = 50;
    localparam int SECURITY_PROG_TIME_US = 1;
    localparam int SE_CYCLES = SECURITY_ERASE_TIME_US * CLK_MHZ;
    localparam int SP_CYCLES = SECURITY_PROG_TIME_US * CLK_MHZ;

    // ****************************************************************
    // Types
    // ****************************************************************
    typedef struct packed {
        logic [1:0] sreg;
        logic [7:0] byte_addr;
    } fsc_ptr_s;

    typedef struct packed {
        fsc_ptr_s ptr;
        logic [7:0] data;
    } fsc_wr_s;

    typedef struct packed {
        logic erase;
        logic prog;
        logic [1:0] sreg;
    } fsc_arm_s;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_ERASE = 2'b01,
        ST_PROG = 2'b10
    } fsc_state_e;

    // Address selects a security register when it has the fixed layout.
    function automatic logic sec_valid(input logic [23:0] addr);
        sec_valid = (addr[23:14] == 10'h000) && (addr[13:12] != 2'b00) &&
            (addr[11:8] == 4'h0);
    endfunction

endpackage

/* File: hw/fsc_sync.sv */
// Two-flop level synchroniser.
`timescale 1ns/1ns
module fsc_sync
    import fsc_pkg::*;
#(
    parameter int WIDTH = 1
)
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);

    logic [WIDTH-1:0] meta_r;

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            meta_r <= '0;
            q <= '0;
        end
        else
        begin
            meta_r <= d;
            q <= meta_r;
        end
    end

endmodule

/* File: hw/fsc_tog_rx.sv */
// Toggle receiver that turns a foreign toggle into a one-cycle pulse.
`timescale 1ns/1ns
module fsc_tog_rx
    import fsc_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic tog,
    output logic pulse
);

    logic tog_s;
    logic tog_q_r;

    fsc_sync #(.WIDTH(1)) u_sync
    (
        .clk(clk),
        .reset_n(reset_n),
        .d(tog),
        .q(tog_s)
    );

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            tog_q_r <= 1'b0;
        else
            tog_q_r <= tog_s;
    end

    assign pulse = tog_s ^ tog_q_r;

endmodule

/* File: hw/fsc_pkg_unused_guard.sv */
// Holds no logic.

/* File: verif/fsc_host.sv */
// Host side of the serial link: clocks out frames and captures replies.
`timescale 1ns/1ns
module fsc_host
(
    output logic spi_clk,
    output logic cs_n,
    output logic [3:0] io_in,
    input wire logic [3:0] io_out,
    input wire logic [3:0] io_oe
);
    logic [3:0] txq [$];
    logic [63:0] got;
    event done;

    initial
    begin
        spi_clk = 1'b0;
        cs_n = 1'b1;
        io_in = 4'h5;
    end

    // Sends every queued nibble, then clocks nrx reply units in.
    task automatic frame(input int nrx, input bit quad);
        logic [3:0] v;
        #1 cs_n = 1'b0;
        while (txq.size() > 0)
        begin
            io_in = txq.pop_front();
            #6 spi_clk = 1'b1;
            #6 spi_clk = 1'b0;
        end
        got = '0;
        for (int i = 0; i < nrx; i++)
        begin
            io_in = ~io_in;
            #6 spi_clk = 1'b1;
            v = io_out & io_oe;
            got = quad ? {got[59:0], v} : {got[62:0], v[1]};
            #6 spi_clk = 1'b0;
        end
        #6 cs_n = 1'b1;
        io_in = ~io_in;
        if (nrx > 0)
            -> done;
    endtask
endmodule

/* File: verif/fsc_top_sva.sv */
// Concurrent checks on the ports of the identification and security block.
`timescale 1ns/1ns
module fsc_top_sva
    import fsc_pkg::*;
#(
    parameter int ERASE_CYCLES = SE_CYCLES,
    parameter int PROG_CYCLES = SP_CYCLES
)
(
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic spi_clk,
    input wire logic cs_n,
    input wire logic [3:0] io_in,
    input wire logic [3:0] io_out,
    input wire logic [3:0] io_oe,
    input wire logic write_enable_latch,
    input wire logic [2:0] otp_lock_bits,
    input wire logic busy,
    input wire logic latch_clr
);
    logic [6:0] edge_cnt;
    logic [7:0] op_sr;
    int busy_cnt;

    always_ff @(posedge spi_clk or posedge cs_n)
    begin
        if (cs_n)
        begin
            edge_cnt <= 7'h00;
            op_sr <= 8'h00;
        end
        else
        begin
            if (edge_cnt != CNT_MAX)
                edge_cnt <= edge_cnt + 7'h01;
            if (edge_cnt < OPC_BITS)
                op_sr <= {op_sr[6:0], io_in[0]};
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
            busy_cnt <= 0;
        else
            busy_cnt <= busy ? busy_cnt + 1 : 0;
    end

    oe_idle_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        cs_n && $past(cs_n) |-> io_oe == 4'h0)
        else $error("output enabled while deselected");
    clr_end_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        latch_clr == $fell(busy))
        else $error("latch clear not at end of busy");
    busy_len_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        $fell(busy) |-> busy_cnt == ERASE_CYCLES || busy_cnt == PROG_CYCLES)
        else $error("busy length wrong");
    busy_cs_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        $rose(busy) |-> cs_n && $past(cs_n))
        else $error("busy rose inside a frame");
    busy_latch_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        $rose(busy) |-> $past(write_enable_latch))
        else $error("busy without write enable");
    op_quiet_a: assert property (@(posedge spi_clk) disable iff (!reset_n || cs_n)
        edge_cnt < OPC_BITS |-> io_oe == 4'h0)
        else $error("output during opcode");
    jedec_oe_a: assert property (@(posedge spi_clk) disable iff (cs_n)
        op_sr == OP_JEDEC && edge_cnt >= OPC_BITS |-> io_oe == 4'h2)
        else $error("jedec reply not on single line");
    quad_oe_a: assert property (@(posedge spi_clk) disable iff (cs_n)
        op_sr == OP_QUAD_ID && edge_cnt >= OPC_BITS
        |-> io_oe == (edge_cnt < START_QUAD ? 4'h0 : 4'hF))
        else $error("quad reply enable wrong");
    long_oe_a: assert property (@(posedge spi_clk) disable iff (cs_n)
        (op_sr == OP_UID || op_sr == OP_TABLE || op_sr == OP_SEC_READ)
        && edge_cnt >= OPC_BITS && edge_cnt < START_LONG |-> io_oe == 4'h0)
        else $error("reply before clock forty");
endmodule

bind fsc_top fsc_top_sva #(.ERASE_CYCLES(ERASE_CYCLES),
    .PROG_CYCLES(PROG_CYCLES)) fsc_top_sva_inst (.clk_sys, .reset_n,
    .spi_clk, .cs_n, .io_in, .io_out, .io_oe, .write_enable_latch,
    .otp_lock_bits, .busy, .latch_clr);

/* File: verif/tb_fsc_top.sv */
// Self-checking bench of the identification and security block.
`timescale 1ns/1ns
module tb_fsc_top;
    import fsc_pkg::*;
    localparam int EC = 300;
    localparam int PC = 20;
    localparam logic [7:0] MFR = 8'hC3; // Arbitrary value.
    localparam logic [7:0] DEV = 8'h21; // Arbitrary value.
    localparam logic [7:0] MEM = 8'h60; // Arbitrary value.
    localparam logic [7:0] CAP = 8'h19; // Arbitrary value.
    localparam logic [63:0] UID = 64'h13579BDF2468ACE0; // Arbitrary.
    logic clk_sys, reset_n, spi_clk, cs_n, busy, latch_clr;
    logic write_enable_latch;
    logic [3:0] io_in, io_out, io_oe;
    logic [2:0] otp_lock_bits;
    logic [7:0] pd [3];
    logic [7:0] a8;
    logic [63:0] exp_q [$];
    int dur_q [$];
    int failures, n_checks, seed, cyc, bcnt;

    fsc_top #(.MFR_ID(MFR), .DEV_ID(DEV), .MEM_TYPE(MEM), .CAPACITY(CAP),
        .UNIQUE_ID(UID), .ERASE_CYCLES(EC), .PROG_CYCLES(PC)) fsc_top_inst (
        .clk_sys, .reset_n, .spi_clk, .cs_n, .io_in, .io_out, .io_oe,
        .write_enable_latch, .otp_lock_bits, .busy, .latch_clr);
    fsc_host fsc_host_inst (.spi_clk, .cs_n, .io_in, .io_out, .io_oe);

    initial
    begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end

    task automatic end_sim();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic chk_rd(input logic [63:0] e, input logic [63:0] g);
        n_checks++;
        if (g !== e)
        begin
            failures++;
            $display("[FAIL] reply exp %h got %h", e, g);
        end
    endtask

    task automatic chk_len(string nm, input logic [31:0] e, g);
        n_checks++;
        if (g !== e)
        begin
            failures++;
            $display("[FAIL] %s exp %0d got %0d", nm, e, g);
        end
    endtask

    function automatic logic [7:0] tbl(input logic [7:0] a);
        return a < TABLE_SIG_BYTES ? TABLE_SIGNATURE[8 * a +: 8] : TABLE_FILL;
    endfunction

    // ****************************************************************
    // Result monitors
    // ****************************************************************
    always @(fsc_host_inst.done)
        chk_rd(exp_q.pop_front(), fsc_host_inst.got);

    always @(negedge clk_sys)
    begin
        cyc++;
        if (cyc > 10000)
        begin
            failures++;
            end_sim();
        end
        if (busy === 1'b1)
            bcnt++;
        if (latch_clr === 1'b1)
        begin
            chk_len("busy length", dur_q.pop_front(), bcnt);
            bcnt = 0;
            write_enable_latch <= 1'b0;
        end
    end

    // ****************************************************************
    // Frame drivers
    // ****************************************************************
    task automatic put(input logic [31:0] v, input int n);
        for (int i = n - 1; i >= 0; i--)
            fsc_host_inst.txq.push_back({3'b000, v[i]});
    endtask

    task automatic rd(input int n, input bit q, input logic [63:0] e);
        exp_q.push_back(e);
        fsc_host_inst.frame(n, q);
        repeat (5) @(negedge clk_sys);
    endtask

    task automatic rdsec(input logic [23:0] a, input int n,
        input logic [63:0] e);
        put(OP_SEC_READ, 8);
        put(a, 24);
        put($random(seed), 8);
        rd(8 * n, 0, e);
    endtask

    task automatic cmd(input logic [7:0] op, input logic [23:0] a,
        input int nd, input int tail, input bit ok);
        put(op, 8);
        put(a, 24);
        for (int i = 0; i < nd; i++)
            put(pd[i], 8);
        put($random(seed), tail);
        if (ok)
            dur_q.push_back(op == OP_SEC_ERASE ? EC : PC);
        fsc_host_inst.frame(0, 0);
        repeat (8) @(negedge clk_sys);
        chk_len("busy", {31'h0, ok}, {31'h0, busy});
    endtask

    task automatic idle();
        for (int i = 0; i < 400 && busy !== 1'b0; i++)
            @(negedge clk_sys);
        repeat (2) @(negedge clk_sys);
    endtask

    initial
    begin
        seed = 32'h29B1EFFA;
        reset_n = 1'b0;
        write_enable_latch = 1'b0;
        otp_lock_bits = 3'h0;
        repeat (6) @(negedge clk_sys);
        reset_n = 1'b1;
        repeat (4) @(negedge clk_sys);
        put(OP_JEDEC, 8);
        rd(32, 0, {32'h0, MFR, MEM, CAP, 8'h00});
        put(OP_QUAD_ID, 8);
        for (int i = 0; i < 12; i++)
            fsc_host_inst.txq.push_back((i < 4 || i == 11) ?
                4'($random(seed)) : (i == 10 ? 4'hF : 4'h0));
        rd(8, 1, {32'h0, MFR, DEV, MFR, DEV});
        put(OP_UID, 8);
        put($random(seed), 32);
        rd(64, 0, UID);
        for (int k = 0; k < 2; k++)
        begin
            a8 = k ? 8'hFE : 8'($random(seed));
            put(OP_TABLE, 8);
            put({16'h0, a8}, 24);
            put($random(seed), 8);
            rd(32, 0, {32'h0, tbl(a8), tbl(a8 + 8'h01), tbl(a8 + 8'h02),
                tbl(a8 + 8'h03)});
        end
        put(OP_TABLE, 8);
        put(24'h000100, 24);
        put($random(seed), 8);
        rd(32, 0, 64'h0);
        cmd(OP_SEC_ERASE, 24'h001000, 0, 0, 0);
        for (int k = 1; k <= 3; k++)
        begin
            write_enable_latch = 1'b1;
            cmd(OP_SEC_ERASE, {8'h00, 4'(k), 12'h000}, 0, 0, 1);
            idle();
        end
        write_enable_latch = 1'b1;
        cmd(OP_SEC_ERASE, 24'h001000, 0, 1, 0);
        cmd(OP_SEC_ERASE, 24'h004000, 0, 0, 0);
        for (int k = 0; k < 3; k++)
            pd[k] = 8'($random(seed));
        cmd(OP_SEC_PROG, 24'h0020FE, 3, 0, 1);
        idle();
        rdsec(24'h0020FD, 5, {24'h0, 8'hFF, pd[0], pd[1], pd[2], 8'hFF});
        otp_lock_bits = 3'b100;
        write_enable_latch = 1'b1;
        cmd(OP_SEC_PROG, 24'h003000, 1, 0, 0);
        cmd(OP_SEC_ERASE, 24'h003000, 0, 0, 0);
        rdsec(24'h003000, 4, 64'hFFFFFFFF);
        cmd(OP_SEC_ERASE, 24'h001000, 0, 0, 1);
        rdsec(24'h001000, 2, 64'h0);
        idle();
        chk_len("latch clears", 0, dur_q.size());
        chk_len("replies", 0, exp_q.size());
        end_sim();
    end
endmodule
